/* File: async_serial_port.sv */
/*
 async serial port control and status: avalon-mm slave, control registers,
 flags, receiver and sleep/wake logic; instantiates rate divider and tx shifter.
 assumes RXD_IN is already synchronous to MCLK_IN and idles high.
*/
`timescale 1ns/10ps
module async_serial_port import serial_port_pkg::*; (
	input wire logic MCLK_IN,
	input wire logic RST_IN,
	input wire logic [7:0] ADDRESS_IN,
	input wire logic READ_IN,
	input wire logic WRITE_IN,
	input wire logic [31:0] WRITEDATA_IN,
	input wire logic [3:0] BYTEENABLE_IN,
	input wire logic RXD_IN,
	output logic [31:0] READDATA_OUT,
	output logic WAITREQUEST_OUT,
	output logic TXD_OUT,
	output logic IRQ_OUT
);
	typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} rx_state_t;

	serial_tick_if tk ();

	logic wait_q;
	logic [31:0] rdata_q;
	logic irq_q;
	logic [7:0] ctrl_one_q;
	logic [7:0] ctrl_two_q;
	logic [7:0] baud_q;
	logic [7:0] tx_hold_q;
	logic hold_full_q;
	logic tx_holding_empty_flag_q;
	logic tc_q;
	logic armed_q;
	logic [7:0] rx_hold_q;
	logic rx_ninth_q;
	logic rx_full_q;
	logic idle_q;
	logic overrun_q;
	logic noise_q;
	logic stop_err_q;
	logic quiet_armed_q;
	rx_state_t rx_state_q;
	logic [3:0] rx_tick_q;
	logic [3:0] bit_idx_q;
	logic [8:0] shift_q;
	logic [2:0] votes_q;
	logic noise_acc_q;
	logic rx_done_q;
	logic stop_bad_q;
	logic [3:0] ones_q;
	logic [3:0] idle_tick_q;
	logic [7:0] rd_mux;
	logic [7:0] flags_w;
	logic tx_take;
	logic tx_busy;

	// bus decode
	logic ack_now, wr, rd;
	logic hit_one, hit_two, hit_flags, hit_data, hit_baud;
	logic data_wr, data_rd, flags_rd, wr_two;
	assign ack_now = (READ_IN || WRITE_IN) && wait_q;
	assign wr = WRITE_IN && ack_now && BYTEENABLE_IN[0];
	assign rd = READ_IN && ack_now;
	assign hit_one = (ADDRESS_IN == ADDR_CTRL_ONE);
	assign hit_two = (ADDRESS_IN == ADDR_CTRL_TWO);
	assign hit_flags = (ADDRESS_IN == ADDR_FLAGS);
	assign hit_data = (ADDRESS_IN == ADDR_DATA);
	assign hit_baud = (ADDRESS_IN == ADDR_BAUD);
	assign data_wr = wr && hit_data;
	assign data_rd = rd && hit_data;
	assign flags_rd = rd && hit_flags;
	assign wr_two = wr && hit_two;

	// configuration fields
	logic nine, wake_m, rx_en, tx_en, sleep, brk;
	assign nine = ctrl_one_q[CO_MODE];
	assign wake_m = ctrl_one_q[CO_WAKE];
	assign rx_en = ctrl_two_q[CT_RX_EN];
	assign tx_en = ctrl_two_q[CT_TX_EN];
	assign sleep = ctrl_two_q[CT_SLEEP];
	assign brk = ctrl_two_q[CT_BREAK];
	assign tk.nine_bit = nine;

	// receiver helpers: 3-sample majority vote, noise on disagreement
	logic vote, noisy, at_bit_end, start_seen;
	logic [3:0] data_last, quiet_thr;
	logic [7:0] rx_byte;
	assign vote = (votes_q[0] & votes_q[1]) | (votes_q[0] & votes_q[2]) |
		(votes_q[1] & votes_q[2]);
	assign noisy = (|votes_q) && !(&votes_q);
	assign at_bit_end = (rx_tick_q == TICK_LAST);
	assign start_seen = rx_en && tk.tick16 && (rx_state_q == RX_IDLE) && !RXD_IN;
	assign data_last = nine ? DATA_LAST_NINE : DATA_LAST_EIGHT;
	assign quiet_thr = frame_bits(nine);
	assign rx_byte = nine ? shift_q[7:0] : shift_q[8:1];

	// frame completion, wake-up and transfer decisions
	logic addr_wake, idle_wake, wake_now, xfer, load_now, ovr_set, rx_clr, quiet_set;
	assign addr_wake = rx_done_q && sleep && wake_m && shift_q[8];
	assign idle_wake = sleep && !wake_m && (ones_q > quiet_thr);
	assign wake_now = addr_wake || idle_wake;
	assign xfer = rx_done_q && (!sleep || addr_wake);
	assign load_now = xfer && !rx_full_q;
	assign ovr_set = xfer && rx_full_q;
	assign rx_clr = data_rd && armed_q;
	assign quiet_set = rx_en && !sleep && quiet_armed_q && (ones_q >= quiet_thr);

	assign flags_w = {tx_holding_empty_flag_q, tc_q, rx_full_q, idle_q, overrun_q, noise_q, stop_err_q, 1'b0};

	// read selection; unmapped addresses read zero
	always_comb begin
		rd_mux = 8'h00;
		if (hit_one) begin
			rd_mux = {rx_ninth_q, ctrl_one_q[6:0]};
		end else if (hit_two) begin
			rd_mux = ctrl_two_q;
		end else if (hit_flags) begin
			rd_mux = flags_w;
		end else if (hit_data) begin
			rd_mux = rx_hold_q;
		end else if (hit_baud) begin
			rd_mux = baud_q;
		end
	end

	// avalon slave: every access answered one cycle after it appears
	always_ff @(posedge MCLK_IN) begin
		if (RST_IN) begin
			wait_q <= 1'b1;
			rdata_q <= 32'h0;
		end else begin
			wait_q <= !ack_now;
			if (ack_now) begin
				rdata_q <= READ_IN ? {24'h0, rd_mux} : 32'h0;
			end
		end
	end
	assign READDATA_OUT = rdata_q;
	assign WAITREQUEST_OUT = wait_q;

	// control registers; software sleep request beats a wake in the same cycle
	always_ff @(posedge MCLK_IN) begin
		if (RST_IN) begin
			ctrl_one_q <= CTRL_ONE_RST;
			ctrl_two_q <= CTRL_TWO_RST;
			baud_q <= BAUD_RST;
		end else begin
			if (wr && hit_one) begin
				ctrl_one_q <= WRITEDATA_IN[7:0] & CTRL_ONE_WMASK;
			end
			if (wr_two) begin
				ctrl_two_q <= WRITEDATA_IN[7:0];
			end else if (wake_now) begin
				ctrl_two_q[CT_SLEEP] <= 1'b0;
			end
			if (wr && hit_baud) begin
				baud_q <= WRITEDATA_IN[7:0] & BAUD_WMASK;
			end
		end
	end

	// transmit holding register and its flags; set wins over clear
	always_ff @(posedge MCLK_IN) begin
		if (RST_IN) begin
			tx_hold_q <= 8'h00;
			hold_full_q <= 1'b0;
			tx_holding_empty_flag_q <= 1'b1;
			tc_q <= 1'b1;
			armed_q <= 1'b0;
		end else begin
			if (data_wr) begin
				tx_hold_q <= WRITEDATA_IN[7:0];
			end
			hold_full_q <= data_wr || (hold_full_q && !tx_take);
			tx_holding_empty_flag_q <= tx_take || (tx_holding_empty_flag_q && !(data_wr && armed_q));
			tc_q <= !hold_full_q && !tx_busy;
			// a flags read arms exactly one following data access
			if (flags_rd) begin
				armed_q <= 1'b1;
			end else if (data_wr || data_rd) begin
				armed_q <= 1'b0;
			end
		end
	end

	// receive flags: noise and stop errors only with a loaded character, overrun beats clear
	always_ff @(posedge MCLK_IN) begin
		if (RST_IN) begin
			rx_hold_q <= 8'h00;
			rx_ninth_q <= 1'b0;
			rx_full_q <= 1'b0;
			idle_q <= 1'b0;
			overrun_q <= 1'b0;
			noise_q <= 1'b0;
			stop_err_q <= 1'b0;
			quiet_armed_q <= 1'b0;
		end else begin
			if (load_now) begin
				rx_hold_q <= rx_byte;
				rx_ninth_q <= nine && shift_q[8];
			end
			rx_full_q <= load_now || (rx_full_q && !rx_clr);
			idle_q <= quiet_set || (idle_q && !rx_clr);
			overrun_q <= ovr_set || (overrun_q && !rx_clr);
			noise_q <= (load_now && noise_acc_q) || (noise_q && !rx_clr);
			stop_err_q <= (load_now && stop_bad_q) || (stop_err_q && !rx_clr);
			if (start_seen) begin
				quiet_armed_q <= 1'b1;
			end else if (quiet_set) begin
				quiet_armed_q <= 1'b0;
			end
		end
	end

	// receive state machine, stepped on the 16x tick
	always_ff @(posedge MCLK_IN) begin
		if (RST_IN) begin
			rx_state_q <= RX_IDLE;
			rx_tick_q <= 4'h0;
			bit_idx_q <= 4'h0;
			shift_q <= 9'h000;
			votes_q <= 3'h7;
			noise_acc_q <= 1'b0;
			rx_done_q <= 1'b0;
			stop_bad_q <= 1'b0;
			ones_q <= 4'h0;
			idle_tick_q <= 4'h0;
		end else begin
			rx_done_q <= 1'b0;
			if (!rx_en) begin
				rx_state_q <= RX_IDLE;
				ones_q <= 4'h0;
				idle_tick_q <= 4'h0;
			end else if (tk.tick16) begin
				rx_tick_q <= rx_tick_q + 4'h1;
				if (rx_tick_q == SAMPLE_A) votes_q[0] <= RXD_IN;
				if (rx_tick_q == SAMPLE_B) votes_q[1] <= RXD_IN;
				if (rx_tick_q == SAMPLE_C) votes_q[2] <= RXD_IN;
				case (rx_state_q)
					RX_IDLE: begin
						rx_tick_q <= 4'h1;
						if (!RXD_IN) begin
							rx_state_q <= RX_START;
							ones_q <= 4'h0;
							idle_tick_q <= 4'h0;
						end else begin
							idle_tick_q <= idle_tick_q + 4'h1;
							if (idle_tick_q == TICK_LAST && ones_q != ONES_MAX) begin
								ones_q <= ones_q + 4'h1;
							end
						end
					end
					RX_START: if (at_bit_end) begin
						// a high majority is a glitch, not a start bit
						if (vote) begin
							rx_state_q <= RX_IDLE;
						end else begin
							rx_state_q <= RX_DATA;
							bit_idx_q <= 4'h0;
							noise_acc_q <= noisy;
						end
					end
					RX_DATA: if (at_bit_end) begin
						shift_q <= {vote, shift_q[8:1]};
						noise_acc_q <= noise_acc_q || noisy;
						if (bit_idx_q == data_last) begin
							rx_state_q <= RX_STOP;
						end else begin
							bit_idx_q <= bit_idx_q + 4'h1;
						end
					end
					RX_STOP: if (at_bit_end) begin
						rx_done_q <= 1'b1;
						stop_bad_q <= !vote;
						noise_acc_q <= noise_acc_q || noisy;
						rx_state_q <= RX_IDLE;
						ones_q <= vote ? 4'h1 : 4'h0; // stop bit counts as idle
						idle_tick_q <= 4'h0;
					end
					default: rx_state_q <= RX_IDLE;
				endcase
			end
		end
	end

	// one request line, gated by the four enables
	always_ff @(posedge MCLK_IN) begin
		if (RST_IN) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= (ctrl_two_q[CT_TX_EMPTY_IE] && tx_holding_empty_flag_q) ||
				(ctrl_two_q[CT_TX_DONE_IE] && tc_q) ||
				(ctrl_two_q[CT_RX_IE] && (rx_full_q || overrun_q)) ||
				(ctrl_two_q[CT_QUIET_IE] && idle_q);
		end
	end
	assign IRQ_OUT = irq_q;

	serial_rate_div u_div (
		.clk_in(MCLK_IN),
		.rst_in(RST_IN),
		.pre_sel_in(baud_q[BD_PRE_LO +: 2]),
		.rate_sel_in(baud_q[BD_RATE_LO +: 3]),
		.tk(tk.src)
	);

	serial_tx_shifter u_tx (
		.clk_in(MCLK_IN),
		.rst_in(RST_IN),
		.tk(tk.shf),
		.enable_in(tx_en),
		.start_valid_in(hold_full_q),
		.data_in({ctrl_one_q[CO_TX_NINTH], tx_hold_q}),
		.break_in(brk),
		.take_out(tx_take),
		.busy_out(tx_busy),
		.line_out(TXD_OUT)
	);

	default clocking cb @(posedge MCLK_IN); endclocking
	default disable iff (RST_IN);
	ninth_rx_a: assert property (load_now && nine |=> rx_ninth_q == $past(shift_q[8]))
		else $error("ninth received bit not captured");
	addr_wake_a: assert property (addr_wake && !wr_two && !rx_clr |=> !sleep && rx_full_q)
		else $error("address mark did not wake and load");
	idle_wake_a: assert property (sleep && !wake_m && ones_q == 4'(quiet_thr + 4'h1)
		&& !wr_two |=> !sleep)
		else $error("idle wake count wrong");
	sleep_block_a: assert property (sleep && !wake_m && rx_done_q |=> !$rose(rx_full_q))
		else $error("sleeping receiver loaded data");
	tx_holding_empty_flag_set_a: assert property (tx_take |=> tx_holding_empty_flag_q)
		else $error("holding-empty flag not set on transfer");
	tx_holding_empty_flag_clr_a: assert property (data_wr && armed_q && !tx_take |=> !tx_holding_empty_flag_q)
		else $error("holding-empty flag not cleared");
	done_busy_a: assert property (tx_busy |=> !tc_q)
		else $error("done flag set while shifting");
	err_together_a: assert property ($rose(noise_q) || $rose(stop_err_q) |-> $rose(rx_full_q))
		else $error("error flag apart from receive-full");
	idle_once_a: assert property (!quiet_armed_q && !idle_q |=> !idle_q)
		else $error("idle flag set again without activity");
	rx_clear_a: assert property (rx_clr && !rx_done_q |=> !rx_full_q && !overrun_q)
		else $error("read sequence did not clear receive flags");
	overrun_keep_a: assert property (ovr_set |=> overrun_q && $stable(rx_hold_q))
		else $error("overrun lost old character");
	bus_answer_a: assert property ((READ_IN || WRITE_IN) && WAITREQUEST_OUT |=> !WAITREQUEST_OUT)
		else $error("bus access not answered next cycle");
	cover_load_c: cover property (load_now);
	cover_ovr_c: cover property (ovr_set);
	cover_wake_c: cover property (addr_wake);
	cover_quiet_c: cover property (quiet_set);
endmodule // async_serial_port

/* File: serial_far_end.sv */
/*
 far end of the serial line: remote transmitter and receiver, 16 clocks a bit.
 assumes the port's baud register is 0x00, so the 16x tick runs every clock.
*/
`timescale 1ns/10ps
module serial_far_end (
	input wire logic clk_in,
	input wire logic txd_in,
	output logic rxd_out
);
	initial rxd_out = 1'b1; // line idles high

	// low start, data lsb first, stop, then one idle bit so the next start shows
	task automatic send(input logic [8:0] d, input int nb, input logic stop);
		logic [11:0] f;
		f = ({3'h0, d} << 1) | (12'(stop) << (nb + 1)) | (12'h001 << (nb + 2));
		for (int i = 0; i <= nb + 2; i++) begin
			@(posedge clk_in);
			rxd_out <= f[i];
			repeat (15) @(posedge clk_in);
		end
	endtask

	// same frame with one stop bit, but a one-clock glitch inside data bit 1
	task automatic send_noisy(input logic [8:0] d, input int nb);
		logic [11:0] f;
		f = ({3'h0, d} << 1) | (12'h003 << (nb + 1));
		for (int i = 0; i <= nb + 2; i++) begin
			@(posedge clk_in);
			rxd_out <= f[i];
			repeat (7) @(posedge clk_in);
			if (i == 2) rxd_out <= !f[i];
			@(posedge clk_in);
			rxd_out <= f[i];
			repeat (7) @(posedge clk_in);
		end
	endtask

	// capture one frame, sampling mid-bit after the falling start edge
	task automatic recv(input int nb, output logic [8:0] d, output logic stop);
		d = 9'h000;
		while (txd_in !== 1'b0) @(posedge clk_in);
		repeat (8) @(posedge clk_in);
		for (int i = 0; i < nb; i++) begin
			repeat (16) @(posedge clk_in);
			d[i] = txd_in;
		end
		repeat (16) @(posedge clk_in);
		stop = txd_in;
	endtask
endmodule // serial_far_end

/* File: serial_port_pkg.sv */
/*
 package for the async serial port: register indices and byte addresses,
 field positions, reset values, write masks and bit timing counts.
 assumes a 32-bit avalon-mm slave with one register per aligned word.
*/
package serial_port_pkg;
	localparam int unsigned CLK_HZ = 25_000_000; // MCLK_IN rate
	// register indices; byte address is four times the index
	localparam logic [7:0] IDX_CTRL_ONE = 8'h0e;
	localparam logic [7:0] IDX_CTRL_TWO = 8'h0f;
	localparam logic [7:0] IDX_FLAGS = 8'h10;
	localparam logic [7:0] IDX_DATA = 8'h11;
	localparam logic [7:0] IDX_BAUD = 8'h12;
	localparam logic [7:0] ADDR_CTRL_ONE = 8'(IDX_CTRL_ONE * 4);
	localparam logic [7:0] ADDR_CTRL_TWO = 8'(IDX_CTRL_TWO * 4);
	localparam logic [7:0] ADDR_FLAGS = 8'(IDX_FLAGS * 4);
	localparam logic [7:0] ADDR_DATA = 8'(IDX_DATA * 4);
	localparam logic [7:0] ADDR_BAUD = 8'(IDX_BAUD * 4);
	// serial_ctrl_one fields
	localparam int CO_RX_NINTH = 7;
	localparam int CO_TX_NINTH = 6;
	localparam int CO_MODE = 4;
	localparam int CO_WAKE = 3;
	// serial_ctrl_two fields
	localparam int CT_TX_EMPTY_IE = 7;
	localparam int CT_TX_DONE_IE = 6;
	localparam int CT_RX_IE = 5;
	localparam int CT_QUIET_IE = 4;
	localparam int CT_TX_EN = 3;
	localparam int CT_RX_EN = 2;
	localparam int CT_SLEEP = 1;
	localparam int CT_BREAK = 0;
	// baud register fields
	localparam int BD_PRE_LO = 4;
	localparam int BD_RATE_LO = 0;
	// reset values and write masks
	localparam logic [7:0] CTRL_ONE_RST = 8'h00;
	localparam logic [7:0] CTRL_TWO_RST = 8'h00;
	localparam logic [7:0] BAUD_RST = 8'h00;
	localparam logic [7:0] CTRL_ONE_WMASK = 8'h58;
	localparam logic [7:0] BAUD_WMASK = 8'h37;
	// prescaler divide values, minus one
	localparam logic [3:0] PRE_LAST0 = 4'h0;
	localparam logic [3:0] PRE_LAST1 = 4'h2;
	localparam logic [3:0] PRE_LAST2 = 4'h3;
	localparam logic [3:0] PRE_LAST3 = 4'hc;
	// bit timing in 16x ticks
	localparam logic [3:0] TICK_LAST = 4'hf;
	localparam logic [3:0] SAMPLE_A = 4'h7;
	localparam logic [3:0] SAMPLE_B = 4'h8;
	localparam logic [3:0] SAMPLE_C = 4'h9;
	localparam logic [3:0] FRAME_BITS_EIGHT = 4'ha;
	localparam logic [3:0] FRAME_BITS_NINE = 4'hb;
	localparam logic [3:0] DATA_LAST_EIGHT = 4'h7;
	localparam logic [3:0] DATA_LAST_NINE = 4'h8;
	localparam logic [3:0] ONES_MAX = 4'hf;
	localparam logic [11:0] BRK_FRAME_EIGHT = 12'h400;
	localparam logic [11:0] BRK_FRAME_NINE = 12'h800;

	// bits in one frame: start, data, stop
	function automatic logic [3:0] frame_bits(input logic nine);
		return nine ? FRAME_BITS_NINE : FRAME_BITS_EIGHT;
	endfunction
endpackage

/* File: serial_rate_div.sv */
/*
 rate divider: prescaler then power-of-two divider give the 16x tick.
 assumes select inputs come from registers and change rarely.
*/
`timescale 1ns/10ps
module serial_rate_div import serial_port_pkg::*; #(
	parameter int RATE_W = 7
) (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic [1:0] pre_sel_in,
	input wire logic [2:0] rate_sel_in,
	serial_tick_if.src tk
);
	if (RATE_W < 7) begin : g_bad_width
		$error("RATE_W must hold a count of 127");
	end
	logic [3:0] pre_q;
	logic [RATE_W-1:0] rate_q;
	logic [3:0] pre_last;
	logic [RATE_W-1:0] rate_last;
	logic pre_wrap;
	// selection of both divide values
	assign pre_last = (pre_sel_in == 2'h0) ? PRE_LAST0 :
		(pre_sel_in == 2'h1) ? PRE_LAST1 :
		(pre_sel_in == 2'h2) ? PRE_LAST2 : PRE_LAST3;
	assign rate_last = RATE_W'((32'h1 << rate_sel_in) - 32'h1);
	assign pre_wrap = (pre_q == pre_last);

	// cascade; a select change mid-count only stretches one tick
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			pre_q <= 4'h0;
			rate_q <= '0;
			tk.tick16 <= 1'b0;
		end else begin
			tk.tick16 <= 1'b0;
			if (!pre_wrap) begin
				pre_q <= pre_q + 4'h1;
			end else begin
				pre_q <= 4'h0;
				if (rate_q >= rate_last) begin
					rate_q <= '0;
					tk.tick16 <= 1'b1;
				end else begin
					rate_q <= rate_q + 1'b1;
				end
			end
		end
	end
endmodule // serial_rate_div

/* File: serial_tick_if.sv */
/*
 carrier between the port's own modules: the 16x bit tick and frame length.
 assumes one clock domain; the tick is a one-cycle enable.
*/
`timescale 1ns/10ps
interface serial_tick_if;
	logic tick16;
	logic nine_bit;
	modport src (output tick16);
	modport shf (input tick16, input nine_bit);
endinterface

/* File: serial_tx_shifter.sv */
/*
 transmit shifter: sends one data frame or one break, lsb first, 16 ticks a bit.
 assumes the holding register and its flags live in the parent.
*/
`timescale 1ns/10ps
module serial_tx_shifter import serial_port_pkg::*; (
	input wire logic clk_in,
	input wire logic rst_in,
	serial_tick_if.shf tk,
	input wire logic enable_in,
	input wire logic start_valid_in,
	input wire logic [8:0] data_in,
	input wire logic break_in,
	output logic take_out,
	output logic busy_out,
	output logic line_out
);
	logic [11:0] sr_q;
	logic [3:0] left_q;
	logic [3:0] tick_q;
	logic go;
	logic bit_end;
	logic [3:0] n_bits;
	logic [11:0] frame_w;
	logic [11:0] brk_w;
	// frame images: start bit in bit 0, stop and fill ones above
	assign n_bits = frame_bits(tk.nine_bit);
	assign frame_w = tk.nine_bit ? {2'b11, data_in[8], data_in[7:0], 1'b0} :
		{3'b111, data_in[7:0], 1'b0};
	assign brk_w = tk.nine_bit ? BRK_FRAME_NINE : BRK_FRAME_EIGHT;
	assign go = enable_in && (left_q == 4'h0) && (start_valid_in || break_in);
	assign bit_end = tk.tick16 && (tick_q == TICK_LAST);
	assign busy_out = (left_q != 4'h0);

	// data wins over a pending break; break repeats while held
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			sr_q <= 12'hfff;
			left_q <= 4'h0;
			tick_q <= 4'h0;
			line_out <= 1'b1;
			take_out <= 1'b0;
		end else begin
			take_out <= go && start_valid_in;
			if (go) begin
				sr_q <= start_valid_in ? frame_w : brk_w;
				left_q <= start_valid_in ? n_bits : 4'(n_bits + 4'h1);
				tick_q <= 4'h0;
				line_out <= 1'b0;
			end else if (busy_out && tk.tick16) begin
				tick_q <= tick_q + 4'h1;
				if (bit_end) begin
					sr_q <= {1'b1, sr_q[11:1]};
					left_q <= left_q - 4'h1;
					line_out <= (left_q == 4'h1) ? 1'b1 : sr_q[1];
				end
			end
		end
	end

	default clocking cb @(posedge clk_in); endclocking
	default disable iff (rst_in);
	start_low_a: assert property (go |=> !line_out && busy_out)
		else $error("frame did not open with a low start bit");
	break_len_a: assert property (go && !start_valid_in |=>
		left_q == 4'($past(n_bits) + 4'h1))
		else $error("break length wrong");
	idle_high_a: assert property (!busy_out && !$past(go) |-> line_out)
		else $error("line not high while idle");
	cover_break_c: cover property (go && !start_valid_in);
endmodule // serial_tx_shifter

/* File: tb_async_serial_port.sv */
/*
 testbench for the async serial port: avalon-mm master tasks, one task per case.
 assumes baud 0x00 (16 clocks a bit) and the far-end model on the line.
*/
`timescale 1ns/10ps
module tb_async_serial_port import serial_port_pkg::*;;
	logic mclk = 1'b0;
	logic rst = 1'b1;
	logic [7:0] addr = 8'h00;
	logic rd_en = 1'b0;
	logic wr_en = 1'b0;
	logic [31:0] wdata = 32'h0;
	logic rxd;
	logic [31:0] rdata;
	logic wait_rq;
	logic txd;
	logic irq;
	logic [7:0] q;
	logic [8:0] d9;
	logic sb;
	int failures = 0;
	int total_checks = 0;

	always #20 mclk = ~mclk; // 25 MHz

	async_serial_port u_async_serial_port (.MCLK_IN(mclk), .RST_IN(rst), .ADDRESS_IN(addr),
		.READ_IN(rd_en), .WRITE_IN(wr_en), .WRITEDATA_IN(wdata), .BYTEENABLE_IN(4'hf),
		.RXD_IN(rxd), .READDATA_OUT(rdata), .WAITREQUEST_OUT(wait_rq), .TXD_OUT(txd),
		.IRQ_OUT(irq));
	serial_far_end u_serial_far_end (.clk_in(mclk), .txd_in(txd), .rxd_out(rxd));

	// held until waitrequest is sampled low; no fixed latency assumed
	task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
		@(posedge mclk);
		addr <= a;
		wr_en <= w;
		rd_en <= !w;
		wdata <= {24'h0, d};
		do @(posedge mclk); while (wait_rq !== 1'b0);
		q = rdata[7:0];
		wr_en <= 1'b0;
		rd_en <= 1'b0;
	endtask
	task automatic chk(input string nm, input logic [8:0] e, input logic [8:0] g);
		total_checks++;
		if (g !== e) begin
			failures++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		bus(1'b1, a, d);
	endtask
	task automatic rd(input logic [7:0] a, input logic [8:0] e, input string nm);
		bus(1'b0, a, 8'h00);
		chk(nm, e, {1'b0, q});
	endtask
	task automatic give_verdict();
		if (failures == 0 && total_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	// reset values, masked fields, unmapped read, interrupt enables
	task automatic t_regs();
		rd(ADDR_CTRL_ONE, 9'h000, "ctrl_one");
		rd(ADDR_CTRL_TWO, 9'h000, "ctrl_two");
		rd(ADDR_FLAGS, 9'h0c0, "flags");
		rd(8'h00, 9'h000, "unmapped");
		wr(ADDR_CTRL_ONE, 8'hff);
		rd(ADDR_CTRL_ONE, 9'h058, "ctrl_one");
		wr(ADDR_CTRL_ONE, 8'h00);
		for (int i = 0; i < 4; i++) begin
			wr(ADDR_CTRL_TWO, 8'h80 >> i);
			repeat (3) @(posedge mclk);
			chk("irq", {8'h00, i < 2}, {8'h00, irq});
		end
		wr(ADDR_CTRL_TWO, 8'h00);
	endtask
	// data waits while the transmitter is off, then leaves lsb first
	task automatic t_tx();
		rd(ADDR_FLAGS, 9'h0c0, "flags");
		wr(ADDR_DATA, 8'ha5);
		rd(ADDR_FLAGS, 9'h000, "flags");
		fork
			u_serial_far_end.recv(8, d9, sb);
			begin
				wr(ADDR_CTRL_TWO, 8'h08);
				repeat (60) @(posedge mclk);
				rd(ADDR_FLAGS, 9'h080, "flags");
			end
		join
		chk("tx_data", 9'h0a5, d9);
		chk("tx_stop", 9'h001, {8'h00, sb});
		repeat (20) @(posedge mclk);
		rd(ADDR_FLAGS, 9'h0c0, "flags");
	endtask
	task automatic t_tx9();
		wr(ADDR_CTRL_ONE, 8'h50);
		rd(ADDR_FLAGS, 9'h0c0, "flags");
		fork
			u_serial_far_end.recv(9, d9, sb);
			wr(ADDR_DATA, 8'h3c);
		join
		chk("tx_data9", 9'h13c, d9);
		repeat (20) @(posedge mclk);
	endtask
	// nine-bit break: 11 bits of 16 clocks low, cleared before it repeats
	task automatic t_break();
		int n;
		n = 0;
		fork
			begin
				wr(ADDR_CTRL_TWO, 8'h09);
				repeat (30) @(posedge mclk);
				wr(ADDR_CTRL_TWO, 8'h08);
			end
			begin
				while (txd !== 1'b0) @(posedge mclk);
				while (txd === 1'b0) begin
					@(posedge mclk);
					n++;
				end
			end
		join
		chk("break_len", 9'h0b0, 9'(n));
		repeat (40) @(posedge mclk);
		chk("break_end", 9'h001, {8'h00, txd});
	endtask
	task automatic t_rx();
		wr(ADDR_CTRL_ONE, 8'h00);
		wr(ADDR_CTRL_TWO, 8'h04);
		u_serial_far_end.send(9'h05a, 8, 1'b1);
		rd(ADDR_FLAGS, 9'h0e0, "flags");
		rd(ADDR_DATA, 9'h05a, "rx_data");
		rd(ADDR_FLAGS, 9'h0c0, "flags");
		repeat (200) @(posedge mclk);
		rd(ADDR_FLAGS, 9'h0d0, "flags");
		rd(ADDR_DATA, 9'h05a, "rx_data");
		repeat (200) @(posedge mclk);
		rd(ADDR_FLAGS, 9'h0c0, "flags");
	endtask
	// stop error on the first character, second one lost to overrun
	task automatic t_err();
		u_serial_far_end.send(9'h081, 8, 1'b0);
		u_serial_far_end.send(9'h07e, 8, 1'b1);
		rd(ADDR_FLAGS, 9'h0ea, "flags");
		rd(ADDR_DATA, 9'h081, "rx_data");
		rd(ADDR_FLAGS, 9'h0c0, "flags");
		u_serial_far_end.send_noisy(9'h03c, 8);
		rd(ADDR_FLAGS, 9'h0e4, "flags");
		rd(ADDR_DATA, 9'h03c, "rx_data");
		rd(ADDR_FLAGS, 9'h0c0, "flags");
	endtask
	// sleeping receiver ignores a frame whose ninth bit is clear
	task automatic t_wake();
		wr(ADDR_CTRL_ONE, 8'h18);
		wr(ADDR_CTRL_TWO, 8'h06);
		u_serial_far_end.send(9'h091, 9, 1'b1);
		rd(ADDR_FLAGS, 9'h0c0, "flags");
		u_serial_far_end.send(9'h191, 9, 1'b1);
		rd(ADDR_FLAGS, 9'h0e0, "flags");
		rd(ADDR_CTRL_ONE, 9'h098, "ctrl_one");
		rd(ADDR_CTRL_TWO, 9'h004, "ctrl_two");
		rd(ADDR_DATA, 9'h091, "rx_data");
		wr(ADDR_CTRL_ONE, 8'h00);
		wr(ADDR_CTRL_TWO, 8'h16);
		repeat (250) @(posedge mclk);
		rd(ADDR_CTRL_TWO, 9'h014, "ctrl_two");
		rd(ADDR_FLAGS, 9'h0d0, "flags");
		chk("irq", 9'h001, {8'h00, irq});
	endtask

	// main sequence after 16 cycles of reset
	initial begin
		repeat (16) @(posedge mclk);
		rst <= 1'b0;
		t_regs();
		t_tx();
		t_tx9();
		t_break();
		t_rx();
		t_err();
		t_wake();
		give_verdict();
	end
	// watchdog, several times the expected run length
	initial begin
		repeat (20000) @(posedge mclk);
		failures++;
		give_verdict();
	end
endmodule // tb_async_serial_port
